// file: scd_chk_sva.sv
// Pin checker for scd_ctrl.
// Bound to scd_ctrl by the testbench.
`timescale 1ns/1ns
module scd_chk (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire logic init_done,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [8:0] mux_address_pins,
	input wire logic dq_oe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	int gap;
	// Slack: a due refresh may wait for an open row
	always_ff @(posedge ref_clk) begin
		gap <= (!rstn || ($fell(ras_n) && !cas_n)) ? 0 : gap + 1;
	end
	AST_NO_TAKE: assert property (!init_done |-> !req_ready) else $error("early take");
	AST_INIT_CBR: assert property ($fell(ras_n) && !init_done |-> !cas_n) else $error("init not cbr");
	AST_REF_GAP: assert property (init_done |-> gap < 600) else $error("refresh late");
	AST_ROW_PH: assert property ($fell(ras_n) && cas_n |-> cas_n [*3]) else $error("cas early");
	AST_DRV_WR: assert property ($fell(we_n) |-> dq_oe) else $error("write data not driven");
	AST_NO_FIGHT: assert property (dq_oe |-> oe_n) else $error("drive with gate low");
	AST_RMW_OE: assert property ($fell(we_n) && !cas_n |-> oe_n) else $error("gate low in write");
	AST_COL_HOLD: assert property ($rose(ras_n) |-> $stable(mux_address_pins)) else $error("col moved");
	AST_RD_RSP: assert property ($fell(cas_n) && !ras_n && we_n |-> ##5 rsp_valid) else $error("no rsp");
	cover property (rsp_valid);
	cover property ($fell(ras_n) && !cas_n && init_done);
	cover property ($fell(we_n) && !cas_n);
endmodule // scd_chk

// file: scd_ctrl.sv
// Host-side controller that drives a static column DRAM through its pins.
// Assumes the DRAM data pins are shared; the testbench resolves the wire from dq_oe.
// How it works
// [RL1] Idle pause, then initialisation refresh cycles
// [RL2] Eight column-before-row cycles used for initialisation
// [RL3] Refresh one row at least every interval
// [RL4] Row-only refresh: row low, column high
// [RL5] Device floats data during row-only refresh
// [RL6] Column low before row: internal refresh
// [RL7] Device advances its refresh counter
// [RL8] Hidden refresh keeps previous read data
// [RL9] Static column: row held, new columns
// [RL10] Column held across row rise
// [RL11] Write with early strobe floats output
// [RL12] Data never sampled on write cycles
// [RL13] Read, write, modify freely mixed per row
// [RL14] Modify: read with gate low, then write
// [RL15] Write data stable before strobes fall; plain writes raise dq_oe in the same clock as the strobes fall
// [RL16] Read data sampled only after column low
// [RL17] Nine row bits, then nine column bits
// [RL18] Row strobe held low between accesses
// [RL19] Both strobes high means standby
// [RL20] Device counter wraps over 512 rows
`timescale 1ns/1ns
module scd_ctrl (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic req_valid,
	input wire logic [1:0] req_op,
	input wire logic [8:0] req_row,
	input wire logic [8:0] req_col,
	input wire logic [3:0] req_wdata,
	input wire logic req_last,
	output logic req_ready,
	output logic rsp_valid,
	output logic [3:0] rsp_rdata,
	output logic init_done,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic oe_n,
	output logic [8:0] mux_address_pins,
	output logic [3:0] dq_out,
	output logic dq_oe,
	input wire logic [3:0] dq_in
);
	scd_pkg::scd_state_e state;
	logic [31:0] pause_cnt;
	logic [31:0] ref_cnt;
	logic ref_due;
	logic [1:0] ph;
	logic [3:0] init_cnt;
	logic [1:0] op;
	logic last;
	logic [8:0] open_row;
	logic [3:0] dq_s1;
	logic [3:0] dq_s2;
	logic [3:0] dq_s3;
	logic [3:0] dq_st;
	logic [8:0] col;
	logic rd_hold;
	logic ph_end;

	assign ph_end = (ph == scd_pkg::PH_LAST);

	////////////////////////////////////////////////////////////
	// Read data passes three flops since the DRAM is asynchronous
	always_ff @(posedge ref_clk) begin
		dq_s1 <= dq_in;
		dq_s2 <= dq_s1;
		dq_s3 <= dq_s2;
	end

	// A new value counts only once the last two stages agree
	always_ff @(posedge ref_clk) begin
		if (dq_s2 == dq_s3)
			dq_st <= dq_s3;
	end

	////////////////////////////////////////////////////////////
	// Refresh interval: one row per tick keeps all rows inside the period
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ref_cnt <= 32'h0;
		end else if (ref_cnt == 32'(scd_pkg::REF_INTERVAL_CYC - 1)) begin
			ref_cnt <= 32'h0;
		end else begin
			ref_cnt <= ref_cnt + 32'h1;
		end
	end

	// A tick in the cycle that ends a refresh wins, so no interval is lost
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ref_due <= 1'b0;
		end else if (ref_cnt == 32'(scd_pkg::REF_INTERVAL_CYC - 1)) begin
			ref_due <= 1'b1; // RL3
		end else if (state == scd_pkg::SCD_REF_RAS && ph_end) begin
			ref_due <= 1'b0; // RL3
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ph <= 2'h0;
		end else if (state == scd_pkg::SCD_IDLE || state == scd_pkg::SCD_OPEN || state == scd_pkg::SCD_PAUSE || ph_end) begin
			ph <= 2'h0;
		end else begin
			ph <= ph + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////
	// Main sequencer; each strobe phase lasts three clocks (120 ns)
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state <= scd_pkg::SCD_PAUSE;
			pause_cnt <= 32'h0;
			init_cnt <= 4'h0;
			init_done <= 1'b0;
			ras_n <= 1'b1;
			cas_n <= 1'b1;
			we_n <= 1'b1;
			oe_n <= 1'b1;
			mux_address_pins <= 9'h0;
			dq_out <= 4'h0;
			dq_oe <= 1'b0;
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= 4'h0;
			op <= 2'h0;
			last <= 1'b0;
			open_row <= 9'h0;
			col <= 9'h0;
			rd_hold <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			req_ready <= 1'b0;
			unique case (state)
				scd_pkg::SCD_PAUSE: begin
					ras_n <= 1'b1; // RL1
					cas_n <= 1'b1; // RL19
					pause_cnt <= pause_cnt + 32'h1;
					if (pause_cnt == 32'(scd_pkg::PAUSE_CYC - 1))
						state <= scd_pkg::SCD_INIT_CAS;
				end
				scd_pkg::SCD_INIT_CAS: begin
					cas_n <= 1'b0; // RL2
					if (ph_end)
						state <= scd_pkg::SCD_INIT_RAS;
				end
				scd_pkg::SCD_INIT_RAS: begin
					ras_n <= 1'b0; // RL6
					if (ph_end) begin
						ras_n <= 1'b1;
						cas_n <= 1'b1;
						init_cnt <= init_cnt + 4'h1;
						if (init_cnt == scd_pkg::INIT_LAST) begin
							init_done <= 1'b1; // RL1
							state <= scd_pkg::SCD_PRE;
						end else begin
							// Pause is spent once; the next init cycle follows at once
							state <= scd_pkg::SCD_INIT_CAS; // RL2
						end
					end
				end
				scd_pkg::SCD_IDLE: begin
					ras_n <= 1'b1; // RL19
					cas_n <= 1'b1;
					if (ref_due) begin
						state <= scd_pkg::SCD_REF_CAS;
					end else if (req_valid) begin
						req_ready <= 1'b1;
						op <= req_op;
						last <= req_last;
						open_row <= req_row;
						col <= req_col;
						dq_out <= req_wdata;
						mux_address_pins <= req_row; // RL17
						state <= scd_pkg::SCD_ROW;
					end
				end
				scd_pkg::SCD_ROW: begin
					// Column is taken with the request; the bus may move on meanwhile
					ras_n <= 1'b0; // RL17
					cas_n <= 1'b1; // RL4
					if (ph_end) begin
						mux_address_pins <= col;
						state <= scd_pkg::SCD_COL;
					end
				end
				scd_pkg::SCD_COL: begin
					// Column latched on the column strobe; write strobe falls in the same clock
					cas_n <= 1'b0;
					we_n <= (op != 2'(scd_pkg::SCD_OP_WRITE)); // RL11
					oe_n <= (op == 2'(scd_pkg::SCD_OP_WRITE)); // RL14
					dq_oe <= (op == 2'(scd_pkg::SCD_OP_WRITE)); // RL15
					if (ph_end) begin
						if (op != 2'(scd_pkg::SCD_OP_WRITE) && !rd_hold) begin
							// Second phase lets read data clear the three-flop path
							rd_hold <= 1'b1;
						end else begin
							rd_hold <= 1'b0;
							if (op != 2'(scd_pkg::SCD_OP_WRITE)) begin
								rsp_valid <= 1'b1; // RL16
								rsp_rdata <= dq_st; // RL12
							end
							if (op == 2'(scd_pkg::SCD_OP_RMW))
								state <= scd_pkg::SCD_RMW_WR;
							else
								state <= last ? scd_pkg::SCD_CLOSE : scd_pkg::SCD_OPEN;
						end
					end
				end
				scd_pkg::SCD_RMW_WR: begin
					oe_n <= 1'b1; // RL14
					dq_oe <= 1'b1;
					if (ph == 2'h1)
						we_n <= 1'b0; // RL15
					if (ph_end)
						state <= last ? scd_pkg::SCD_CLOSE : scd_pkg::SCD_OPEN;
				end
				scd_pkg::SCD_OPEN: begin
					// Row stays low; next access only changes the column
					we_n <= 1'b1;
					oe_n <= 1'b1;
					dq_oe <= 1'b0;
					// A due refresh goes first so same-row traffic cannot starve it
					if (ref_due) begin
						state <= scd_pkg::SCD_CLOSE; // RL3
					end else if (req_valid && req_row == open_row) begin // RL9
						req_ready <= 1'b1;
						op <= req_op;
						last <= req_last;
						dq_out <= req_wdata;
						mux_address_pins <= req_col; // RL18
						state <= scd_pkg::SCD_COL; // RL13
					end else if (req_valid) begin
						state <= scd_pkg::SCD_CLOSE;
					end
				end
				scd_pkg::SCD_CLOSE: begin
					// Column address held while row rises so the final latch is clean
					ras_n <= 1'b1; // RL10
					we_n <= 1'b1;
					oe_n <= 1'b1;
					dq_oe <= 1'b0;
					if (ph_end) begin
						cas_n <= 1'b1;
						state <= scd_pkg::SCD_PRE;
					end
				end
				scd_pkg::SCD_PRE: begin
					ras_n <= 1'b1;
					cas_n <= 1'b1;
					if (ph_end)
						state <= scd_pkg::SCD_IDLE;
				end
				scd_pkg::SCD_REF_CAS: begin
					cas_n <= 1'b0; // RL6
					if (ph_end)
						state <= scd_pkg::SCD_REF_RAS;
				end
				scd_pkg::SCD_REF_RAS: begin
					ras_n <= 1'b0; // RL7
					if (ph_end) begin
						ras_n <= 1'b1;
						cas_n <= 1'b1;
						state <= scd_pkg::SCD_PRE; // RL20
					end
				end
				default: state <= scd_pkg::SCD_PAUSE;
			endcase
		end
	end
endmodule // scd_ctrl

// file: scd_dram.sv
// Behavioural 256K x 4 static column DRAM at the controller pins.
// Assumes the testbench resolves the shared data wire.
`timescale 1ns/1ns
module scd_dram (
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [8:0] mux_address_pins,
	input wire logic [3:0] dq_in,
	output logic [3:0] dram_q
);
	logic [3:0] mem [0:262143];
	logic [3:0] last = 4'h5;
	logic [8:0] row, ref_row = 9'h000;
	logic cbr = 1'b0, rd;
	always @(negedge ras_n) begin
		cbr = !cas_n;
		if (cbr) ref_row = ref_row + 9'h001;
		else row = mux_address_pins;
	end
	// Delay lets write data land in the strobe's time step
	always @(negedge cas_n or negedge we_n) begin
		#1;
		if (!ras_n && !cas_n && !we_n && !cbr) mem[{row, mux_address_pins}] = dq_in;
	end
	assign rd = !ras_n && !cas_n && we_n && !oe_n && !cbr;
	always @* if (rd) last = mem[{row, mux_address_pins}];
	// Released pins show the inverse of the last value
	assign dram_q = rd ? last : ~last;
endmodule // scd_dram

// file: scd_pkg.sv
// Package for the static column DRAM controller: timing counts, widths, states.
// Assumes a 25 MHz ref_clk and an asynchronous 256K x 4 static column DRAM.
package scd_pkg;
	localparam int CLK_MHZ = 25;
	localparam int ADDR_W = 9;
	localparam int DATA_W = 4;
	localparam int ROWS = 512;
	localparam int INIT_CYCLES = 8;
	localparam int PAUSE_US = 200;
	localparam int PAUSE_CYC = PAUSE_US * CLK_MHZ;
	localparam int REF_PERIOD_US = 8200;
	localparam int REF_INTERVAL_CYC = (REF_PERIOD_US * CLK_MHZ) / ROWS;
	localparam int PHASE_CYC = 3;
	localparam logic [1:0] PH_LAST = 2'h2;
	localparam logic [3:0] INIT_LAST = 4'h7;

	typedef enum logic [3:0] {
		SCD_PAUSE = 4'h0,
		SCD_INIT_CAS = 4'h1,
		SCD_INIT_RAS = 4'h2,
		SCD_IDLE = 4'h3,
		SCD_ROW = 4'h4,
		SCD_COL = 4'h5,
		SCD_RMW_WR = 4'h6,
		SCD_OPEN = 4'h7,
		SCD_CLOSE = 4'h8,
		SCD_PRE = 4'h9,
		SCD_REF_CAS = 4'ha,
		SCD_REF_RAS = 4'hb
	} scd_state_e;

	typedef enum logic [1:0] {
		SCD_OP_READ = 2'h0,
		SCD_OP_WRITE = 2'h1,
		SCD_OP_RMW = 2'h2
	} scd_op_e;
endpackage

// file: tb.sv
// Self-checking bench: scd_ctrl, DRAM model, reference memory.
// Assumes the fixed power-up pause of about 5000 cycles.
`timescale 1ns/1ns
module tb;
	logic ref_clk = 1'b0, rstn, req_valid, req_last, req_ready, rsp_valid, init_done, ras_n, cas_n, we_n, oe_n, dq_oe;
	logic [1:0] req_op;
	logic [8:0] req_row, req_col, mux_address_pins;
	logic [3:0] req_wdata, rsp_rdata, dq_out, dq_in, dram_q;
	logic [31:0] seed = 32'hf53d1f7e;
	logic [3:0] ref_m [int];
	logic [3:0] exp_q [$];
	int n_mismatch = 0, total_checks = 0, i;
	scd_ctrl uut (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.req_valid(req_valid),
		.req_op(req_op),
		.req_row(req_row),
		.req_col(req_col),
		.req_wdata(req_wdata),
		.req_last(req_last),
		.req_ready(req_ready),
		.rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata),
		.init_done(init_done),
		.ras_n(ras_n),
		.cas_n(cas_n),
		.we_n(we_n),
		.oe_n(oe_n),
		.mux_address_pins(mux_address_pins),
		.dq_out(dq_out),
		.dq_oe(dq_oe),
		.dq_in(dq_in)
	);
	scd_dram dram (
		.ras_n(ras_n),
		.cas_n(cas_n),
		.we_n(we_n),
		.oe_n(oe_n),
		.mux_address_pins(mux_address_pins),
		.dq_in(dq_in),
		.dram_q(dram_q)
	);
	assign dq_in = dq_oe ? dq_out : dram_q;
	initial forever #20 ref_clk = ~ref_clk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
		total_checks++;
		if (seen !== want) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Key picks row 0 or 511 and column 0..6 or 511
	task automatic req(input logic [1:0] op, input logic [3:0] k, input logic last);
		int n;
		logic [17:0] a;
		a = {k[3] ? 9'h1ff : 9'h000, k[2:0] == 3'h7 ? 9'h1ff : {6'h00, k[2:0]}};
		seed = lfsr(seed);
		@(negedge ref_clk);
		req_valid = 1'b1;
		req_op = op;
		{req_row, req_col} = a;
		req_wdata = seed[3:0];
		req_last = last;
		if (op != scd_pkg::SCD_OP_WRITE) exp_q.push_back(ref_m[a]);
		if (op != scd_pkg::SCD_OP_READ) ref_m[a] = seed[3:0];
		for (n = 0; n < 2000; n++) begin
			@(negedge ref_clk);
			if (req_ready === 1'b1) break;
		end
		if (n == 2000) begin
			chk("ready", 0, 1);
			results();
		end else begin
			req_valid = 1'b0;
		end
	endtask
	always @(negedge ref_clk) begin
		if (rstn && rsp_valid === 1'b1) begin
			if (exp_q.size() == 0) chk("spare rsp", 1, 0);
			else chk("rdata", rsp_rdata, exp_q.pop_front());
		end
	end
	initial begin
		rstn = 1'b0;
		{req_valid, req_last, req_op, req_row, req_col, req_wdata} = '0;
		repeat (5) @(negedge ref_clk);
		chk("reset pins", {ras_n, cas_n, we_n, oe_n, dq_oe, req_ready}, 6'h3c);
		rstn = 1'b1;
		for (i = 0; i < 8000 && init_done !== 1'b1; i++) @(negedge ref_clk);
		chk("init time", i >= 5000 && i < 8000, 1);
		if (init_done !== 1'b1) begin
			results();
		end else begin
			for (i = 0; i < 16; i++) req(scd_pkg::SCD_OP_WRITE, i[3:0], i[0]);
			for (i = 0; i < 48; i++) begin
				seed = lfsr(seed);
				req(seed[1:0] == 2'h3 ? 2'(scd_pkg::SCD_OP_RMW) : seed[1:0], seed[7:4], seed[8]);
			end
			req(scd_pkg::SCD_OP_READ, 4'h0, 1'b1);
			repeat (1500) @(negedge ref_clk);
			chk("rsp left", exp_q.size(), 0);
			results();
		end
	end
endmodule // tb
bind scd_ctrl scd_chk chk_i (
	.ref_clk(ref_clk),
	.rstn(rstn),
	.req_ready(req_ready),
	.rsp_valid(rsp_valid),
	.init_done(init_done),
	.ras_n(ras_n),
	.cas_n(cas_n),
	.we_n(we_n),
	.oe_n(oe_n),
	.mux_address_pins(mux_address_pins),
	.dq_oe(dq_oe)
);
